// ### hw/ssf_pkg.sv
// shared constants and types for the serdes framer with loopback
`default_nettype none
package ssf_pkg;
    // register byte offsets
    localparam int          AXI_ADDR_W   = 4;
    localparam logic [3:0]  ADDR_CTRL    = 4'h0;
    localparam logic [3:0]  ADDR_STATUS  = 4'h4;
    localparam logic [3:0]  ADDR_FRAMES  = 4'h8;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // control field positions and reset value
    localparam int          CTRL_FAC_BIT  = 0;
    localparam int          CTRL_EQU_BIT  = 1;
    localparam int          CTRL_LT_BIT   = 2;
    localparam int          CTRL_HI_BIT   = 3;
    localparam int          CTRL_REF_BIT  = 4;
    localparam int          CTRL_W        = 5;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;

    // status field positions
    localparam int          STAT_LOSS_BIT  = 0;
    localparam int          STAT_FOUND_BIT = 1;
    localparam int          STAT_HUNT_BIT  = 2;
    localparam int          STAT_DIV_LSB   = 8;

    // clock multiplier feedback ratios
    localparam logic [5:0]  FB_DIV_REF_LO  = 6'h20;
    localparam logic [5:0]  FB_DIV_REF_HI  = 6'h08;

    // framing pattern
    localparam logic [7:0]  PAT_A1         = 8'hF6;
    localparam logic [7:0]  PAT_A2         = 8'h28;
    localparam int          PAT_REPEAT     = 3;
    localparam int          PAT_W          = 16 * PAT_REPEAT;
    localparam int          HUNT_LEAD_BYTES = 4;

    // byte clock phase: tx high for bit counts below this, rx high from this up
    localparam logic [2:0]  BCLK_HALF      = 3'h4;
    localparam logic [2:0]  BIT_LAST       = 3'h7;

    typedef struct packed {
        logic ref_sel;
        logic high_rate;
        logic loop_timing;
        logic equip_loop;
        logic fac_loop;
    } ssf_ctrl_t;

    typedef enum logic [0:0] {
        FS_SEARCH = 1'b0,
        FS_FOUND  = 1'b1
    } ssf_fstate_t;
endpackage
`default_nettype wire

// ### hw/ssf_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module ssf_sync #(
    parameter int W = 1
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } ssf_sync_st_t;

    ssf_sync_st_t st;
    ssf_sync_st_t next_st;

    always_comb
    begin
        next_st      = st;
        next_st.meta = d;
        next_st.sync = st.meta;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign q = st.sync;
endmodule
`default_nettype wire

// ### hw/ssf_frame_det.sv
// framing pattern compare over a sliding bit window
`timescale 1ns/1ns
`default_nettype none
module ssf_frame_det (
    input  wire logic [ssf_pkg::PAT_W-1:0] window,
    output logic                           hit
);
    localparam logic [ssf_pkg::PAT_W-1:0] PATTERN =
        {{ssf_pkg::PAT_REPEAT{ssf_pkg::PAT_A1}}, {ssf_pkg::PAT_REPEAT{ssf_pkg::PAT_A2}}};

    // window moves one bit per received bit, so every offset is tried
    assign hit = (window == PATTERN);
endmodule
`default_nettype wire

// ### hw/ssf_top.sv
// byte-wide serdes with frame detect, signal loss, loopbacks and loop timing
// Behaviour
// - framer byte taken at our tx byte clock rise
// - transmit bytes serialised most significant bit first
// - byte rate times eight gives serial rate
// - ref select picks divide 8 or 32
// - selects map to reference and output frequencies
// - receive data sampled on serial clock rise
// - deserialise, rx byte clock is serial divide-by-8
// - hunt level keeps realigning while held high
// - detect three A1 then three A2
// - realign bytes starting at third A2 byte
// - one byte long pulse with third A2
// - pulse only while hunting or hunt falling
// - signal loss forces receive bytes low
// - signal loss clocks receive from multiplier
// - facility loop sends receive bits to transmit
// - facility loop still deserialises receive stream
// - equipment loop feeds transmit stream to receiver
// - equipment loop rx clock from transmit bit clock
// - equipment loop still drives transmit output
// - both loops together form split loopback
// - split loop isolates both external paths
// - loop timing clocks everything from receive clock, except receive under signal loss
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module ssf_top #(
    parameter bit          LOSS_ACTIVE_HIGH = 1'b1,
    parameter int          CMU_W            = 4,
    parameter logic [3:0]  CMU_DIV_HI       = 4'h2,
    parameter logic [3:0]  CMU_DIV_LO       = 4'h8
) (
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    input  wire logic [ssf_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [ssf_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    input  wire logic [7:0]                     tx_parallel_in,
    output logic                                tx_byte_clock_out,
    output logic                                tx_serial_out,
    input  wire logic                           rx_serial_in,
    input  wire logic                           rx_serial_clock_in,
    output logic [7:0]                          rx_parallel_out,
    output logic                                rx_byte_clock_out,
    output logic                                frame_pulse,
    input  wire logic                           frame_hunt_in,
    input  wire logic                           signal_loss_in
);
    // all state except the pin synchroniser, registered in one place
    typedef struct packed {
        ssf_pkg::ssf_ctrl_t              ctrl;
        logic                            aw_got;
        logic [ssf_pkg::AXI_ADDR_W-1:0]  aw_addr;
        logic                            w_got;
        logic [31:0]                     w_data;
        logic                            w_lane0;
        logic                            bvalid;
        logic [1:0]                      bresp;
        logic                            rvalid;
        logic [31:0]                     rdata;
        logic [1:0]                      rresp;
        logic [CMU_W-1:0]                cmu_cnt;
        logic [2:0]                      tx_bcnt;
        logic [7:0]                      tx_shift;
        logic                            tx_ser;
        logic                            tx_bclk;
        logic                            rx_clk_d;
        logic [ssf_pkg::PAT_W-1:0]       rx_sr;
        logic [2:0]                      rx_bcnt;
        logic [7:0]                      rx_byte;
        logic                            fp;
        logic                            rx_bclk;
        logic                            hunt_d;
        ssf_pkg::ssf_fstate_t            fstate;
        logic [15:0]                     frames;
    } ssf_top_st_t;

    ssf_top_st_t st;
    ssf_top_st_t next_st;

    logic [3:0]                  pins_s;
    logic                        rx_data_s;
    logic                        rx_clk_s;
    logic                        hunt_s;
    logic                        loss_raw_s;
    logic [ssf_pkg::PAT_W-1:0]   rx_window;
    logic                        pat_hit;

    // one synchroniser for all pins keeps data and clock aligned
    ssf_sync #(
        .W (4)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({rx_serial_in, rx_serial_clock_in, frame_hunt_in, signal_loss_in}),
        .q       (pins_s)
    );

    assign rx_data_s  = pins_s[3];
    assign rx_clk_s   = pins_s[2];
    assign hunt_s     = pins_s[1];
    assign loss_raw_s = pins_s[0];

    ssf_frame_det u_det (
        .window (rx_window),
        .hit    (pat_hit)
    );

    // helpers, set on every path of the process below
    logic              loss;
    logic              rx_rise;
    logic              cmu_tick;
    logic [CMU_W-1:0]  cmu_period;
    logic              tx_en;
    logic              rx_en;
    logic              rx_bit;
    logic              hunt_ok;
    logic [31:0]       status_word;

    always_comb
    begin
        next_st = st;

        loss = LOSS_ACTIVE_HIGH ? loss_raw_s : ~loss_raw_s;

        // serial clock edge from the synchronised pin
        rx_rise         = rx_clk_s & ~st.rx_clk_d;
        next_st.rx_clk_d = rx_clk_s;

        // clock multiplier: one bit enable per period, rate picks period
        cmu_period = st.ctrl.high_rate ? CMU_DIV_HI[CMU_W-1:0] : CMU_DIV_LO[CMU_W-1:0];
        cmu_tick   = (st.cmu_cnt >= cmu_period - CMU_W'(1));
        next_st.cmu_cnt = cmu_tick ? '0 : st.cmu_cnt + CMU_W'(1);

        // transmit bit clock, bypassed to the receive clock in loop timing
        tx_en = st.ctrl.loop_timing ? rx_rise : cmu_tick;

        // receive bit clock and source selection
        // equipment loop outranks loss: the line is not used
        if (st.ctrl.equip_loop)
        begin
            rx_en  = tx_en;
            rx_bit = st.tx_shift[7];
        end
        else if (loss)
        begin
            rx_en  = cmu_tick;
            rx_bit = rx_data_s;
        end
        else
        begin
            rx_en  = rx_rise;
            rx_bit = rx_data_s;
        end

        // transmit serialiser
        // a still bit clock in loop timing freezes the byte clock too
        if (tx_en)
        begin
            if (st.tx_bcnt == ssf_pkg::BIT_LAST)
            begin
                next_st.tx_shift = tx_parallel_in;
                next_st.tx_bcnt  = '0;
            end
            else
            begin
                next_st.tx_shift = {st.tx_shift[6:0], 1'b0};
                next_st.tx_bcnt  = st.tx_bcnt + 3'h1;
            end
        end
        next_st.tx_bclk = (next_st.tx_bcnt < ssf_pkg::BCLK_HALF);

        // serial output: looped receive bits or own stream
        // facility loop follows the line clock, not the bit enable
        if (st.ctrl.fac_loop)
        begin
            if (rx_rise)
                next_st.tx_ser = rx_data_s;
        end
        else if (tx_en)
        begin
            next_st.tx_ser = st.tx_shift[7];
        end

        // receive deserialiser and framing
        // a detection in the cycle the hunt level drops still counts
        hunt_ok   = hunt_s | st.hunt_d;
        next_st.hunt_d = hunt_s;
        // window moves one bit per receive bit enable
        rx_window = {st.rx_sr[ssf_pkg::PAT_W-2:0], rx_bit};
        // fresh hunt clears found; a detection in the same cycle wins
        if (hunt_s && !st.hunt_d)
            next_st.fstate = ssf_pkg::FS_SEARCH;

        if (rx_en)
        begin
            next_st.rx_sr = rx_window;
            if (pat_hit && hunt_ok)
            begin
                // this bit closes the third A2 byte: it becomes a byte boundary
                next_st.rx_byte = rx_window[7:0];
                next_st.fp      = 1'b1;
                next_st.rx_bcnt = '0;
                next_st.fstate  = ssf_pkg::FS_FOUND;
                next_st.frames  = st.frames + 16'h0001;
            end
            else if (st.rx_bcnt == ssf_pkg::BIT_LAST)
            begin
                next_st.rx_byte = rx_window[7:0];
                next_st.fp      = 1'b0;
                next_st.rx_bcnt = '0;
            end
            else
            begin
                next_st.rx_bcnt = st.rx_bcnt + 3'h1;
            end
        end
        // loss wins over any byte formed in this cycle
        if (loss)
            next_st.rx_byte = '0;
        // rises mid-byte so the byte is stable around the edge
        next_st.rx_bclk = (next_st.rx_bcnt >= ssf_pkg::BCLK_HALF);

        // status view
        status_word = '0;
        status_word[ssf_pkg::STAT_LOSS_BIT]  = loss;
        status_word[ssf_pkg::STAT_FOUND_BIT] = (st.fstate == ssf_pkg::FS_FOUND);
        status_word[ssf_pkg::STAT_HUNT_BIT]  = hunt_s;
        // select high means the slow reference, hence the larger ratio
        status_word[ssf_pkg::STAT_DIV_LSB +: 6] =
            st.ctrl.ref_sel ? ssf_pkg::FB_DIV_REF_LO : ssf_pkg::FB_DIV_REF_HI;

        // register bus: write address and data taken in either order
        if (s_axi_awvalid && !st.aw_got && !st.bvalid)
        begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_got && !st.bvalid)
        begin
            next_st.w_got   = 1'b1;
            next_st.w_data  = s_axi_wdata;
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        if (st.aw_got && st.w_got && !st.bvalid)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = ssf_pkg::RESP_OKAY;
            case (st.aw_addr)
                ssf_pkg::ADDR_CTRL:
                begin
                    if (st.w_lane0)
                        next_st.ctrl = st.w_data[ssf_pkg::CTRL_W-1:0];
                end
                ssf_pkg::ADDR_STATUS,
                ssf_pkg::ADDR_FRAMES:
                begin
                    next_st.bresp = ssf_pkg::RESP_OKAY;
                end
                default:
                begin
                    next_st.bresp = ssf_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
        end

        // register bus: read
        if (s_axi_arvalid && !st.rvalid)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = ssf_pkg::RESP_OKAY;
            case (s_axi_araddr)
                ssf_pkg::ADDR_CTRL:   next_st.rdata = {27'h0, st.ctrl};
                ssf_pkg::ADDR_STATUS: next_st.rdata = status_word;
                ssf_pkg::ADDR_FRAMES: next_st.rdata = {16'h0000, st.frames};
                default:
                begin
                    next_st.rdata = '0;
                    next_st.rresp = ssf_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
        end
    end

    // reset loads constants only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st      <= '0;
            st.ctrl <= ssf_pkg::CTRL_RESET[ssf_pkg::CTRL_W-1:0];
            st.fstate <= ssf_pkg::FS_SEARCH;
        end
        else
        begin
            st <= next_st;
        end
    end

    // readies combinational, data straight from flops
    assign s_axi_awready     = ~st.aw_got & ~st.bvalid;
    assign s_axi_wready      = ~st.w_got & ~st.bvalid;
    assign s_axi_bvalid      = st.bvalid;
    assign s_axi_bresp       = st.bresp;
    assign s_axi_arready     = ~st.rvalid;
    assign s_axi_rvalid      = st.rvalid;
    assign s_axi_rdata       = st.rdata;
    assign s_axi_rresp       = st.rresp;
    assign tx_byte_clock_out = st.tx_bclk;
    assign tx_serial_out     = st.tx_ser;
    assign rx_parallel_out   = st.rx_byte;
    assign rx_byte_clock_out = st.rx_bclk;
    assign frame_pulse       = st.fp;
endmodule
`default_nettype wire

// ### tb/ssf_top_checker.sv
// concurrent port checks for the serdes framer block
`timescale 1ns/1ns
`default_nettype none
module ssf_top_checker #(
    parameter bit LOSS_ACTIVE_HIGH = 1'b1
) (
    input wire logic                           aclk,
    input wire logic                           aresetn,
    input wire logic                           s_axi_awvalid,
    input wire logic                           s_axi_awready,
    input wire logic                           s_axi_wvalid,
    input wire logic                           s_axi_wready,
    input wire logic                           s_axi_bvalid,
    input wire logic [ssf_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic                           s_axi_arvalid,
    input wire logic                           s_axi_arready,
    input wire logic [31:0]                    s_axi_rdata,
    input wire logic [1:0]                     s_axi_rresp,
    input wire logic                           s_axi_rvalid,
    input wire logic                           tx_byte_clock_out,
    input wire logic [7:0]                     rx_parallel_out,
    input wire logic                           frame_pulse,
    input wire logic                           frame_hunt_in,
    input wire logic                           signal_loss_in
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_loss_zero: assert property ((signal_loss_in == LOSS_ACTIVE_HIGH)[*4] |-> rx_parallel_out == 8'h00)
        else $error("receive byte not zero under loss");
    a_pulse_a2: assert property ($rose(frame_pulse) |-> rx_parallel_out == 8'h28)
        else $error("frame pulse not on aligned A2");
    a_pulse_hunt: assert property ($rose(frame_pulse) |-> $past(frame_hunt_in, 2) || $past(frame_hunt_in, 3)
        || $past(frame_hunt_in, 4) || $past(frame_hunt_in, 5))
        else $error("frame pulse without hunt");
    a_pulse_span: assert property ($rose(frame_pulse) |-> frame_pulse[*8] ##[1:600] !frame_pulse)
        else $error("frame pulse length wrong");
    a_txclk_high: assert property ($rose(tx_byte_clock_out) |=> tx_byte_clock_out[*3])
        else $error("tx byte clock high too short");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
        |=> s_axi_rresp == ssf_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule

bind ssf_top ssf_top_checker #(.LOSS_ACTIVE_HIGH(LOSS_ACTIVE_HIGH)) u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .tx_byte_clock_out, .rx_parallel_out, .frame_pulse, .frame_hunt_in, .signal_loss_in
);
`default_nettype wire

// ### tb/ssf_framer_model.sv
// framer-side model: feeds transmit bytes on the block's byte clock
`timescale 1ns/1ns
`default_nettype none
module ssf_framer_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       tx_byte_clock_out,
    output logic      [7:0] tx_parallel_in
);
    logic       clk_q;
    logic [3:0] idx;

    // new byte right after a capture edge, so it stands a whole byte
    always @(posedge aclk)
    begin
        clk_q <= aresetn && tx_byte_clock_out;
        if (!aresetn)
        begin
            idx            <= 4'h0;
            tx_parallel_in <= 8'h00;
        end
        else if (tx_byte_clock_out && !clk_q)
        begin
            idx <= idx + 4'h1;
            tx_parallel_in <= (idx < 4'h3) ? 8'hF6 : (idx < 4'h6) ? 8'h28 : {4'h0, idx};
        end
    end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the serdes framer block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  tx_parallel_in, rx_parallel_out, fp_byte = 8'h00;
    logic        tx_byte_clock_out, tx_serial_out, rx_byte_clock_out, frame_pulse;
    logic        rx_serial_in = 1'b0, rx_serial_clock_in = 1'b0, frame_hunt_in = 1'b0;
    logic        signal_loss_in = 1'b0, fchk = 1'b0, fp_q = 1'b0, tq = 1'b0, cq = 1'b0, rq = 1'b0;
    int          error_cnt = 0, checks_done = 0, fp_cnt = 0, tx_tg = 0, c_r = 0, r_tg = 0;
    logic [7:0]  pat [8] = '{8'hF6, 8'hF6, 8'hF6, 8'h28, 8'h28, 8'h28, 8'h00, 8'h00};

    always #50 aclk = ~aclk;

    ssf_top DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .tx_parallel_in, .tx_byte_clock_out, .tx_serial_out, .rx_serial_in, .rx_serial_clock_in,
        .rx_parallel_out, .rx_byte_clock_out, .frame_pulse, .frame_hunt_in, .signal_loss_in
    );
    ssf_framer_model u_fr (.aclk, .aresetn, .tx_byte_clock_out, .tx_parallel_in);

    // edge counters and frame pulse capture
    always @(posedge aclk)
    begin
        {fp_q, tq, cq, rq} <= {frame_pulse, tx_serial_out, tx_byte_clock_out, rx_byte_clock_out};
        tx_tg <= tx_tg + int'(tx_serial_out != tq);
        c_r <= c_r + int'(tx_byte_clock_out && !cq);
        r_tg <= r_tg + int'(rx_byte_clock_out != rq);
        if (frame_pulse && !fp_q)
        begin
            fp_cnt <= fp_cnt + 1;
            fp_byte <= rx_parallel_out;
        end
    end

    function automatic bit bad(input bit ok);
        checks_done++;
        return !ok;
    endfunction

    task automatic err(input string m);
        error_cnt++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    task automatic close_out();
        $display("mismatches %0d of %0d checks", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tmo(input bit h);
        if (!h)
        begin
            err("wait ran out");
            close_out();
        end
    endtask

    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        bit pa, pw, h;
        pa = 1'b1;
        pw = 1'b1;
        h = 1'b0;
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
        for (int n = 0; n < 40 && (pa || pw); n++)
        begin
            @(negedge aclk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            @(posedge aclk);
            {s_axi_awvalid, s_axi_wvalid} <= {pa, pw};
        end
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40 && !h; n++)
        begin
            @(negedge aclk);
            {h, rs} = {s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
        tmo(h && !pa && !pw);
    endtask

    task automatic axr(input logic [3:0] a);
        bit p, h;
        p = 1'b1;
        h = 1'b0;
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        for (int n = 0; n < 40 && p; n++)
        begin
            @(negedge aclk);
            p = !s_axi_arready;
            @(posedge aclk);
            s_axi_arvalid <= p;
        end
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40 && !h; n++)
        begin
            @(negedge aclk);
            {h, rd, rs} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
        tmo(h && !p);
    endtask

    // one serial bit: clock low 4 cycles, high 6 cycles
    task automatic sbit(input logic b);
        {rx_serial_in, rx_serial_clock_in} <= {b, 1'b0};
        repeat (4) @(posedge aclk);
        rx_serial_clock_in <= 1'b1;
        repeat (6) @(posedge aclk);
        if (fchk && bad(tx_serial_out === b)) err("looped bit wrong");
    endtask

    task automatic sbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            sbit(b[i]);
    endtask

    task automatic sframe();
        foreach (pat[i])
            sbyte(pat[i]);
    endtask

    task automatic t_regs();
        axr(ssf_pkg::ADDR_CTRL);
        if (bad(rd === 32'h0)) err("ctrl reset value");
        axw(ssf_pkg::ADDR_CTRL, 32'h10);
        axr(ssf_pkg::ADDR_CTRL);
        if (bad(rd === 32'h10)) err("ctrl readback");
        axr(ssf_pkg::ADDR_STATUS);
        if (bad(rd[13:8] === 6'h20)) err("divide 32");
        axw(ssf_pkg::ADDR_CTRL, 32'h0);
        axr(ssf_pkg::ADDR_STATUS);
        if (bad(rd[13:8] === 6'h08)) err("divide 8");
        axr(4'hC);
        if (bad(rs === ssf_pkg::RESP_SLVERR)) err("unmapped read");
        axw(4'hC, 32'h1);
        if (bad(rs === ssf_pkg::RESP_SLVERR)) err("unmapped write");
    endtask

    task automatic t_rate(input logic [31:0] c, input int exp);
        int a;
        axw(ssf_pkg::ADDR_CTRL, c);
        repeat (64) @(posedge aclk);
        a = c_r;
        repeat (256) @(posedge aclk);
        if (bad(c_r - a == exp)) err("tx byte clock rate");
    endtask

    task automatic t_rx();
        int f;
        frame_hunt_in <= 1'b1;
        sbyte(8'h00);
        sbit(1'b1);
        sbit(1'b0);
        sbit(1'b1);
        f = fp_cnt;
        sframe();
        sframe();
        if (bad(fp_cnt == f + 2)) err("frames while hunting");
        if (bad(fp_byte === 8'h28)) err("aligned byte");
        frame_hunt_in <= 1'b0;
        sframe();
        if (bad(fp_cnt == f + 2)) err("frame without hunt");
        axr(ssf_pkg::ADDR_FRAMES);
        if (bad(rd === 32'(fp_cnt))) err("frame count register");
    endtask

    task automatic t_loops();
        int f, t, r;
        axw(ssf_pkg::ADDR_CTRL, 32'h01);
        frame_hunt_in <= 1'b1;
        {fchk, f} = {1'b1, fp_cnt};
        sbyte(8'h00);
        sframe();
        fchk = 1'b0;
        if (bad(fp_cnt == f + 1)) err("facility loop receive");
        axw(ssf_pkg::ADDR_CTRL, 32'h0A);
        {f, t, r} = {fp_cnt, tx_tg, r_tg};
        for (int n = 0; n < 2000 && fp_cnt < f + 2; n++)
            @(posedge aclk);
        tmo(fp_cnt >= f + 2);
        if (bad(fp_byte === 8'h28)) err("equipment loop byte");
        if (bad(tx_tg > t && r_tg > r)) err("equipment loop clocks");
        axw(ssf_pkg::ADDR_CTRL, 32'h0B);
        {fchk, f} = {1'b1, fp_cnt};
        repeat (4) sbyte(8'hB4);
        fchk = 1'b0;
        if (bad(fp_cnt > f && fp_byte === 8'h28)) err("split loop receive");
    endtask

    task automatic t_loss();
        int r;
        bit z;
        axw(ssf_pkg::ADDR_CTRL, 32'h0);
        signal_loss_in <= 1'b1;
        repeat (8) @(posedge aclk);
        {r, z} = {r_tg, 1'b1};
        repeat (200)
        begin
            @(posedge aclk);
            z = z && (rx_parallel_out === 8'h00);
        end
        if (bad(z)) err("loss data");
        if (bad(r_tg > r)) err("loss rx clock");
        axr(ssf_pkg::ADDR_STATUS);
        if (bad(rd[ssf_pkg::STAT_LOSS_BIT] === 1'b1)) err("loss status");
        signal_loss_in <= 1'b0;
    endtask

    task automatic t_lt();
        int c;
        axw(ssf_pkg::ADDR_CTRL, 32'h04);
        repeat (20) @(posedge aclk);
        c = c_r;
        repeat (200) @(posedge aclk);
        if (bad(c_r == c)) err("tx clock runs without rx clock");
        repeat (2) sbyte(8'h00);
        if (bad(c_r > c)) err("tx clock not from rx clock");
    endtask

    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_rate(32'h08, 16);
        t_rate(32'h00, 4);
        t_rx();
        t_loops();
        t_loss();
        t_lt();
        close_out();
    end
endmodule
`default_nettype wire
